/* File: hw/dmdt_consts.svh */
`ifndef DMDT_CONSTS_SVH
`define DMDT_CONSTS_SVH

// Prefetch queue geometry per variant
`define DMDT_QDEPTH_WIDE    3'h6
`define DMDT_QDEPTH_NARROW  3'h4
`define DMDT_QLEVEL_W       3

// Opcode encodings of the decoded forms
`define DMDT_OPC_SEG_LOAD   8'h8E
`define DMDT_OPC_SEG_STORE  8'h8C
`define DMDT_OPC_TRANS      8'hD7
`define DMDT_OPC_EADDR      8'h8D
`define DMDT_OPC_FAR_DATA   8'hC5
`define DMDT_OPC_FAR_EXTRA  8'hC4
`define DMDT_OPC_FLG_RD     8'h9F
`define DMDT_OPC_FLG_WR     8'h9E
`define DMDT_OPC_MOV_TO_RM  7'h44
`define DMDT_OPC_MOV_FR_RM  7'h45

// Mode field of the mode/register/rm byte, and word bit of the opcode
`define DMDT_MOD_HI         7
`define DMDT_MOD_LO         6
`define DMDT_MOD_REG        2'h3
`define DMDT_W_BIT          0

// Base clock counts
`define DMDT_CLK_REG_OP     8'h02
`define DMDT_CLK_SEGLD_WIDE 8'h09
`define DMDT_CLK_SEGLD_NAR  8'h0D
`define DMDT_CLK_SEGST_WIDE 8'h0B
`define DMDT_CLK_SEGST_NAR  8'h0F
`define DMDT_CLK_TRANS_WIDE 8'h0B
`define DMDT_CLK_TRANS_NAR  8'h0F
`define DMDT_CLK_EADDR      8'h06
`define DMDT_CLK_FAR_WIDE   8'h12
`define DMDT_CLK_FAR_NAR    8'h1A
`define DMDT_CLK_FLG_RD     8'h02
`define DMDT_CLK_FLG_WR     8'h03
`define DMDT_CLK_MOVTO_MEM  8'h0C
`define DMDT_CLK_MOVFR_MEM  8'h09
`define DMDT_CLK_UNSUP      8'h00

// Extra clocks
`define DMDT_WORD_ADJ       8'h04
`define DMDT_HANDOFF_MAX    8'h02
`define DMDT_FETCH_SAT      8'hFF

`endif

/* File: hw/dmdt_pkg.sv */
package dmdt_pkg;

   typedef enum logic [2:0] {
      DMDT_ST_OPC   = 3'h1,
      DMDT_ST_MODRM = 3'h2,
      DMDT_ST_OUT   = 3'h4
   } dmdt_state_e;

   typedef enum logic [3:0] {
      DMDT_F_NONE      = 4'h0,
      DMDT_F_SEG_LOAD  = 4'h1,
      DMDT_F_SEG_STORE = 4'h2,
      DMDT_F_TRANS     = 4'h3,
      DMDT_F_EADDR     = 4'h4,
      DMDT_F_FAR_DATA  = 4'h5,
      DMDT_F_FAR_EXTRA = 4'h6,
      DMDT_F_FLG_RD    = 4'h7,
      DMDT_F_FLG_WR    = 4'h8,
      DMDT_F_MOV_TO_RM = 4'h9,
      DMDT_F_MOV_FR_RM = 4'hA,
      DMDT_F_UNSUP     = 4'hF
   } dmdt_form_e;

   typedef logic [7:0] dmdt_clks_t;

endpackage

/* File: hw/dmdt_queue.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dmdt_consts.svh"
module dmdt_queue (
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic                      narrow,
   input  wire logic                      flush,
   input  wire logic                      in_valid,
   input  wire logic [7:0]                in_byte,
   output logic                           in_ready,
   output logic                           out_valid,
   output logic [7:0]                     out_byte,
   input  wire logic                      out_ready,
   output logic [`DMDT_QLEVEL_W-1:0]      level
);
   import dmdt_pkg::*;

   logic [7:0]                 mem_ff [0:5];
   logic [7:0]                 nxt_mem [0:5];
   logic [`DMDT_QLEVEL_W-1:0]  cnt_ff;
   logic [`DMDT_QLEVEL_W-1:0]  nxt_cnt;
   logic [`DMDT_QLEVEL_W-1:0]  cap;
   logic                       push;
   logic                       pop;

   always_comb begin
      cap       = narrow ? `DMDT_QDEPTH_NARROW : `DMDT_QDEPTH_WIDE;
      in_ready  = (cnt_ff < cap) && !flush;
      out_valid = (cnt_ff != 3'h0) && !flush;
      out_byte  = mem_ff[0];
      level     = cnt_ff;
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      nxt_cnt   = cnt_ff;
      for (int i = 0; i < 6; i++) begin
         nxt_mem[i] = mem_ff[i];
      end
      // Shift register: head always at slot 0, simpler read path
      if (pop) begin
         for (int i = 0; i < 5; i++) begin
            nxt_mem[i] = mem_ff[i+1];
         end
      end
      if (push) begin
         nxt_mem[3'(cnt_ff - {2'h0, pop})] = in_byte;
      end
      nxt_cnt = 3'(cnt_ff + {2'h0, push} - {2'h0, pop});
      if (flush) begin
         nxt_cnt = 3'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_ff <= 3'h0;
         for (int i = 0; i < 6; i++) begin
            mem_ff[i] <= 8'h00;
         end
      end else begin
         cnt_ff <= nxt_cnt;
         for (int i = 0; i < 6; i++) begin
            mem_ff[i] <= nxt_mem[i];
         end
      end
   end
endmodule
`default_nettype wire

/* File: hw/dmdt_top.sv */
// Functional notes
// - Reported counts are minimums, assuming queued bytes and no waits.
// - Branch timing includes clocks spent fetching the first target opcode.
// - Memory-accessing forms may take up to two clocks beyond minimum.
// - Wide-bus variant keeps a 6-byte prefetch queue.
// - Narrow-bus variant keeps a 4-byte prefetch queue.
// - Narrow variant adds four clocks per memory transfer of word operations.
// - Segment load from reg/mem: 2/9 wide, 2/13 narrow.
// - Segment store to reg/mem: 2/11 wide, 2/15 narrow.
// - Table lookup translate: 11 wide, 15 narrow.
// - Load effective address: 6 clocks on both variants.
// - Far pointer with data segment: 18/26 clocks, register mode illegal.
// - Far pointer with extra segment: 18/26 clocks, register mode illegal.
// - Flags to high accumulator byte: 2 clocks.
// - High accumulator byte to flags: 3 clocks.
`timescale 1ns/10ps
`default_nettype none
`include "dmdt_consts.svh"
module dmdt_top (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   narrow_strap,
   input  wire logic                   flush,
   input  wire logic                   fetch_valid,
   input  wire logic [7:0]             fetch_byte,
   output logic                        fetch_ready,
   output logic                        narrow_mode,
   output logic                        dec_valid,
   input  wire logic                   dec_ready,
   output dmdt_pkg::dmdt_form_e        dec_form,
   output logic                        dec_mem,
   output logic                        dec_word,
   output logic                        dec_illegal,
   output dmdt_pkg::dmdt_clks_t        dec_min_clks,
   output dmdt_pkg::dmdt_clks_t        dec_max_clks,
   output dmdt_pkg::dmdt_clks_t        dec_fetch_clks
);
   import dmdt_pkg::*;

   // Strap synchroniser and capture
   logic                       strap_s1_ff;
   logic                       strap_s2_ff;
   logic                       narrow_ff;
   logic                       nxt_narrow;

   // Queue side
   logic                       q_valid;
   logic [7:0]                 q_byte;
   logic                       q_ready;
   logic [`DMDT_QLEVEL_W-1:0]  q_level;

   // Decoder state
   dmdt_state_e                state_ff;
   dmdt_state_e                nxt_state;
   logic [7:0]                 opc_ff;
   logic [7:0]                 nxt_opc;
   dmdt_form_e                 form_ff;
   dmdt_form_e                 nxt_form;
   logic                       mem_ff;
   logic                       nxt_mem;
   logic                       word_ff;
   logic                       nxt_word;
   logic                       ill_ff;
   logic                       nxt_ill;
   dmdt_clks_t                 min_ff;
   dmdt_clks_t                 nxt_min;
   dmdt_clks_t                 max_ff;
   dmdt_clks_t                 nxt_max;
   dmdt_clks_t                 fch_ff;
   dmdt_clks_t                 nxt_fch;

   // Target fetch accounting
   logic                       wait_ff;
   logic                       nxt_wait;
   dmdt_clks_t                 wcnt_ff;
   dmdt_clks_t                 nxt_wcnt;

   logic                       take;
   dmdt_form_e                 cur_form;
   logic                       cur_mem;
   logic                       cur_word;
   dmdt_clks_t                 cur_base;

   function automatic dmdt_form_e opc_form(input logic [7:0] opc);
      dmdt_form_e f;
      f = DMDT_F_UNSUP;
      case (opc)
         `DMDT_OPC_SEG_LOAD:  f = DMDT_F_SEG_LOAD;
         `DMDT_OPC_SEG_STORE: f = DMDT_F_SEG_STORE;
         `DMDT_OPC_TRANS:     f = DMDT_F_TRANS;
         `DMDT_OPC_EADDR:     f = DMDT_F_EADDR;
         `DMDT_OPC_FAR_DATA:  f = DMDT_F_FAR_DATA;
         `DMDT_OPC_FAR_EXTRA: f = DMDT_F_FAR_EXTRA;
         `DMDT_OPC_FLG_RD:    f = DMDT_F_FLG_RD;
         `DMDT_OPC_FLG_WR:    f = DMDT_F_FLG_WR;
         default: begin
            if (opc[7:1] == `DMDT_OPC_MOV_TO_RM) begin
               f = DMDT_F_MOV_TO_RM;
            end else if (opc[7:1] == `DMDT_OPC_MOV_FR_RM) begin
               f = DMDT_F_MOV_FR_RM;
            end
         end
      endcase
      return f;
   endfunction

   function automatic logic has_modrm(input dmdt_form_e f);
      return (f == DMDT_F_SEG_LOAD) || (f == DMDT_F_SEG_STORE) ||
             (f == DMDT_F_EADDR) || (f == DMDT_F_FAR_DATA) ||
             (f == DMDT_F_FAR_EXTRA) || (f == DMDT_F_MOV_TO_RM) ||
             (f == DMDT_F_MOV_FR_RM);
   endfunction

   // Base minimum count of a decoded form
   function automatic dmdt_clks_t base_clks(input dmdt_form_e f,
                                            input logic mem,
                                            input logic word,
                                            input logic nar);
      dmdt_clks_t c;
      c = `DMDT_CLK_UNSUP;
      case (f)
         DMDT_F_SEG_LOAD: begin
            if (!mem) c = `DMDT_CLK_REG_OP;
            else c = nar ? `DMDT_CLK_SEGLD_NAR : `DMDT_CLK_SEGLD_WIDE;
         end
         DMDT_F_SEG_STORE: begin
            if (!mem) c = `DMDT_CLK_REG_OP;
            else c = nar ? `DMDT_CLK_SEGST_NAR : `DMDT_CLK_SEGST_WIDE;
         end
         DMDT_F_TRANS: begin
            c = nar ? `DMDT_CLK_TRANS_NAR : `DMDT_CLK_TRANS_WIDE;
         end
         DMDT_F_EADDR: begin
            c = `DMDT_CLK_EADDR;
         end
         DMDT_F_FAR_DATA, DMDT_F_FAR_EXTRA: begin
            c = nar ? `DMDT_CLK_FAR_NAR : `DMDT_CLK_FAR_WIDE;
         end
         DMDT_F_FLG_RD: begin
            c = `DMDT_CLK_FLG_RD;
         end
         DMDT_F_FLG_WR: begin
            c = `DMDT_CLK_FLG_WR;
         end
         DMDT_F_MOV_TO_RM, DMDT_F_MOV_FR_RM: begin
            if (!mem) begin
               c = `DMDT_CLK_REG_OP;
            end else begin
               c = (f == DMDT_F_MOV_TO_RM) ? `DMDT_CLK_MOVTO_MEM
                                           : `DMDT_CLK_MOVFR_MEM;
               // Byte count listed; one memory transfer per word op
               if (nar && word) begin
                  c = 8'(c + `DMDT_WORD_ADJ);
               end
            end
         end
         default: begin
            c = `DMDT_CLK_UNSUP;
         end
      endcase
      return c;
   endfunction

   dmdt_queue u_queue (
      .clk       (clk),
      .reset     (reset),
      .narrow    (narrow_ff),
      .flush     (flush),
      .in_valid  (fetch_valid),
      .in_byte   (fetch_byte),
      .in_ready  (fetch_ready),
      .out_valid (q_valid),
      .out_byte  (q_byte),
      .out_ready (q_ready),
      .level     (q_level)
   );

   // Variant is latched only while reset is held
   always_comb begin
      nxt_narrow = reset ? strap_s2_ff : narrow_ff;
   end

   always_ff @(posedge clk) begin
      strap_s1_ff <= narrow_strap;
      strap_s2_ff <= strap_s1_ff;
      narrow_ff   <= nxt_narrow;
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_opc   = opc_ff;
      nxt_form  = form_ff;
      nxt_mem   = mem_ff;
      nxt_word  = word_ff;
      nxt_ill   = ill_ff;
      nxt_min   = min_ff;
      nxt_max   = max_ff;
      nxt_fch   = fch_ff;
      q_ready   = 1'b0;
      cur_form  = opc_form(opc_ff);
      cur_mem   = 1'b0;
      cur_word  = opc_ff[`DMDT_W_BIT];
      cur_base  = `DMDT_CLK_UNSUP;
      // Decode takes each byte as soon as it is queued unless a result is pending; waits for bytes are counted only after a flush, so counts stay minimums
      case (state_ff)
         DMDT_ST_OPC: begin
            q_ready  = 1'b1;
            cur_form = opc_form(q_byte);
            cur_word = q_byte[`DMDT_W_BIT];
            if (q_valid) begin
               nxt_opc = q_byte;
               nxt_fch = wait_ff ? wcnt_ff : 8'h00;
               if (has_modrm(cur_form)) begin
                  nxt_state = DMDT_ST_MODRM;
               end else begin
                  cur_mem  = (cur_form == DMDT_F_TRANS);
                  cur_base = base_clks(cur_form, cur_mem, 1'b0, narrow_ff);
                  nxt_form = cur_form;
                  nxt_mem  = cur_mem;
                  nxt_word = 1'b0;
                  nxt_ill  = (cur_form == DMDT_F_UNSUP);
                  nxt_min  = 8'(cur_base + nxt_fch);
                  nxt_max  = 8'(nxt_min +
                                (cur_mem ? `DMDT_HANDOFF_MAX : 8'h00));
                  nxt_state = DMDT_ST_OUT;
               end
            end
         end
         DMDT_ST_MODRM: begin
            q_ready = 1'b1;
            if (q_valid) begin
               cur_mem = (q_byte[`DMDT_MOD_HI:`DMDT_MOD_LO] != `DMDT_MOD_REG);
               // Address computation only; no bus access
               cur_base = base_clks(cur_form, cur_mem, cur_word, narrow_ff);
               nxt_form = cur_form;
               nxt_mem  = cur_mem && (cur_form != DMDT_F_EADDR);
               nxt_word = cur_word && ((cur_form == DMDT_F_MOV_TO_RM) ||
                                       (cur_form == DMDT_F_MOV_FR_RM));
               nxt_ill  = !cur_mem && ((cur_form == DMDT_F_FAR_DATA) ||
                                       (cur_form == DMDT_F_FAR_EXTRA));
               nxt_min  = 8'(cur_base + fch_ff);
               nxt_max  = 8'(nxt_min +
                             (nxt_mem ? `DMDT_HANDOFF_MAX : 8'h00));
               nxt_state = DMDT_ST_OUT;
            end
         end
         DMDT_ST_OUT: begin
            if (dec_ready) begin
               nxt_state = DMDT_ST_OPC;
            end
         end
         default: begin
            nxt_state = DMDT_ST_OPC;
         end
      endcase
      // A flush discards any partly decoded or unclaimed result
      if (flush) begin
         nxt_state = DMDT_ST_OPC;
      end
   end

   assign take = (state_ff == DMDT_ST_OPC) && q_valid && !flush;

   // Clocks from the flush until the target opcode reaches the decoder
   always_comb begin
      nxt_wait = wait_ff;
      nxt_wcnt = wcnt_ff;
      if (flush) begin
         nxt_wait = 1'b1;
         nxt_wcnt = 8'h01;
      end else if (take) begin
         nxt_wait = 1'b0;
         nxt_wcnt = 8'h00;
      end else if (wait_ff && (wcnt_ff != `DMDT_FETCH_SAT)) begin
         nxt_wcnt = 8'(wcnt_ff + 8'h01);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= DMDT_ST_OPC;
         opc_ff   <= 8'h00;
         form_ff  <= DMDT_F_NONE;
         mem_ff   <= 1'b0;
         word_ff  <= 1'b0;
         ill_ff   <= 1'b0;
         min_ff   <= 8'h00;
         max_ff   <= 8'h00;
         fch_ff   <= 8'h00;
         wait_ff  <= 1'b0;
         wcnt_ff  <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         opc_ff   <= nxt_opc;
         form_ff  <= nxt_form;
         mem_ff   <= nxt_mem;
         word_ff  <= nxt_word;
         ill_ff   <= nxt_ill;
         min_ff   <= nxt_min;
         max_ff   <= nxt_max;
         fch_ff   <= nxt_fch;
         wait_ff  <= nxt_wait;
         wcnt_ff  <= nxt_wcnt;
      end
   end

   assign narrow_mode    = narrow_ff;
   assign dec_valid      = (state_ff == DMDT_ST_OUT);
   assign dec_form       = form_ff;
   assign dec_mem        = mem_ff;
   assign dec_word       = word_ff;
   assign dec_illegal    = ill_ff;
   assign dec_min_clks   = min_ff;
   assign dec_max_clks   = max_ff;
   assign dec_fetch_clks = fch_ff;

   dmdt_clks_t base_seen;
   assign base_seen = 8'(dec_min_clks - dec_fetch_clks);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_seg_opc;
      take && (q_byte == `DMDT_OPC_SEG_LOAD);
   endsequence

   sequence s_modrm_take;
      q_valid && !flush;
   endsequence

   AST_HOLD: assert property (dec_valid && !dec_ready && !flush |=>
      dec_valid && $stable(dec_min_clks) && $stable(dec_form))
      else $error("decode result changed before it was taken");
   AST_FETCH: assert property (flush ##1 (!take && !flush) [*2] ##1
      (take && !flush && (wcnt_ff == 8'h03)) |=> (dec_fetch_clks == 8'h03))
      else $error("target fetch clocks miscounted");
   AST_HANDOFF: assert property (dec_valid |->
      (dec_max_clks - dec_min_clks) == (dec_mem ? 8'h02 : 8'h00))
      else $error("handoff slack wrong");
   AST_WIDE_Q: assert property (!narrow_ff |-> q_level <= 3'h6)
      else $error("wide queue over six bytes");
   AST_NAR_Q: assert property (narrow_ff |-> q_level <= 3'h4)
      else $error("narrow queue over four bytes");
   AST_WORD: assert property (dec_valid && narrow_ff && dec_word &&
      dec_mem && dec_form == DMDT_F_MOV_FR_RM |-> base_seen == 8'h0D)
      else $error("word adjustment missing");
   AST_SEG_LOAD: assert property (s_seg_opc ##1 s_modrm_take |=>
      dec_valid && base_seen == (!dec_mem ? 8'h02 :
                                 narrow_ff ? 8'h0D : 8'h09))
      else $error("segment load count wrong");
   AST_SEG_STORE: assert property (dec_valid &&
      dec_form == DMDT_F_SEG_STORE |-> base_seen ==
      (!dec_mem ? 8'h02 : narrow_ff ? 8'h0F : 8'h0B))
      else $error("segment store count wrong");
   AST_TRANS: assert property (dec_valid && dec_form == DMDT_F_TRANS |->
      base_seen == (narrow_ff ? 8'h0F : 8'h0B) && dec_mem)
      else $error("translate count wrong");
   AST_EADDR: assert property (dec_valid && dec_form == DMDT_F_EADDR |->
      base_seen == 8'h06)
      else $error("effective address count wrong");
   AST_FAR: assert property (dec_valid && (dec_form == DMDT_F_FAR_DATA ||
      dec_form == DMDT_F_FAR_EXTRA) |-> dec_illegal == !dec_mem &&
      base_seen == (narrow_ff ? 8'h1A : 8'h12))
      else $error("far pointer decode wrong");
   AST_FLG_RD: assert property (dec_valid && dec_form == DMDT_F_FLG_RD |->
      base_seen == 8'h02)
      else $error("flags read count wrong");
   AST_FLG_WR: assert property (dec_valid && dec_form == DMDT_F_FLG_WR |->
      base_seen == 8'h03)
      else $error("flags write count wrong");
   AST_PAIR: assert property (dec_valid && !dec_mem &&
      (dec_form == DMDT_F_MOV_TO_RM || dec_form == DMDT_F_SEG_STORE) |->
      base_seen == 8'h02)
      else $error("register form did not use first count");
endmodule
`default_nettype wire

/* File: testbench/dmdt_fetch_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dmdt_fetch_model (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       flush,
   input  wire logic       stall,
   input  wire logic       fetch_ready,
   output logic            fetch_valid,
   output logic [7:0]      fetch_byte
);
   logic [7:0] q[$];
   int         taken;

   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask

   initial begin
      fetch_valid = 1'h0;
      fetch_byte  = 8'hA5;
      taken       = 0;
   end

   // Offer held unchanged until the edge that takes it
   always @(posedge clk) begin
      if (reset || flush) begin
         q.delete();
      end else if (fetch_valid && fetch_ready) begin
         void'(q.pop_front());
         taken++;
      end
      // Later than bench drive so pushes land in the same cycle
      #2;
      fetch_valid = !stall && q.size() > 0;
      // Idle bus must not show a stale byte
      fetch_byte = fetch_valid ? q[0] : ~fetch_byte;
   end
endmodule
`default_nettype wire

/* File: testbench/dmdt_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module dmdt_top_bench;
   import dmdt_pkg::*;
   typedef struct {
      logic [7:0] op;
      logic [7:0] mb;
      dmdt_form_e form;
      logic [3:0] flg;
      dmdt_clks_t cw;
      dmdt_clks_t cn;
   } dmdt_row_s;
   logic       clk, reset, narrow_strap, flush, stall, dec_ready;
   logic       fetch_valid, fetch_ready, narrow_mode, dec_valid;
   logic       dec_mem, dec_word, dec_illegal;
   logic [7:0] fetch_byte;
   dmdt_form_e dec_form;
   dmdt_clks_t dec_min_clks, dec_max_clks, dec_fetch_clks;
   int         err_total, checks;
   // Flags: two-byte, memory, word, illegal
   dmdt_row_s  rows[18] = '{
      '{8'h8E, 8'hC0, DMDT_F_SEG_LOAD,  4'h8, 8'h02, 8'h02},
      '{8'h8E, 8'h07, DMDT_F_SEG_LOAD,  4'hC, 8'h09, 8'h0D},
      '{8'h8C, 8'hC3, DMDT_F_SEG_STORE, 4'h8, 8'h02, 8'h02},
      '{8'h8C, 8'h05, DMDT_F_SEG_STORE, 4'hC, 8'h0B, 8'h0F},
      '{8'hD7, 8'h00, DMDT_F_TRANS,     4'h4, 8'h0B, 8'h0F},
      '{8'h8D, 8'h07, DMDT_F_EADDR,     4'h8, 8'h06, 8'h06},
      '{8'h8D, 8'hC1, DMDT_F_EADDR,     4'h8, 8'h06, 8'h06},
      '{8'hC5, 8'h07, DMDT_F_FAR_DATA,  4'hC, 8'h12, 8'h1A},
      '{8'hC5, 8'hC0, DMDT_F_FAR_DATA,  4'h9, 8'h12, 8'h1A},
      '{8'hC4, 8'h04, DMDT_F_FAR_EXTRA, 4'hC, 8'h12, 8'h1A},
      '{8'hC4, 8'hD8, DMDT_F_FAR_EXTRA, 4'h9, 8'h12, 8'h1A},
      '{8'h9F, 8'h00, DMDT_F_FLG_RD,    4'h0, 8'h02, 8'h02},
      '{8'h9E, 8'h00, DMDT_F_FLG_WR,    4'h0, 8'h03, 8'h03},
      '{8'h89, 8'h07, DMDT_F_MOV_TO_RM, 4'hE, 8'h0C, 8'h10},
      '{8'h88, 8'h07, DMDT_F_MOV_TO_RM, 4'hC, 8'h0C, 8'h0C},
      '{8'h8B, 8'h05, DMDT_F_MOV_FR_RM, 4'hE, 8'h09, 8'h0D},
      '{8'h8A, 8'hC2, DMDT_F_MOV_FR_RM, 4'h8, 8'h02, 8'h02},
      '{8'hF4, 8'h00, DMDT_F_UNSUP,     4'h1, 8'h00, 8'h00}
   };

   dmdt_top dmdt_top_inst (
      .clk(clk), .reset(reset), .narrow_strap(narrow_strap),
      .flush(flush), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
      .fetch_ready(fetch_ready), .narrow_mode(narrow_mode),
      .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_form(dec_form),
      .dec_mem(dec_mem), .dec_word(dec_word), .dec_illegal(dec_illegal),
      .dec_min_clks(dec_min_clks), .dec_max_clks(dec_max_clks),
      .dec_fetch_clks(dec_fetch_clks)
   );

   dmdt_fetch_model dmdt_fetch_model_inst (
      .clk(clk), .reset(reset), .flush(flush), .stall(stall),
      .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
      .fetch_byte(fetch_byte)
   );

   initial clk = 1'h0;
   always #50 clk = ~clk;

   task automatic stop_test;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic cmp_bit(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_clk(input string n, input dmdt_clks_t e,
                          input dmdt_clks_t g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_form(input string n, input dmdt_form_e e,
                           input dmdt_form_e g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wait_res;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (dec_valid !== 1'h1 && n < 30);
      cmp_bit("dec_valid", 1'h1, dec_valid);
   endtask

   task automatic accept;
      dec_ready = 1'h1;
      @(posedge clk);
      #1;
      dec_ready = 1'h0;
   endtask

   task automatic run_row(input dmdt_row_s r, input logic nar);
      dmdt_clks_t m;
      m = nar ? r.cn : r.cw;
      dmdt_fetch_model_inst.push(r.op);
      if (r.flg[3])
         dmdt_fetch_model_inst.push(r.mb);
      wait_res();
      cmp_form("dec_form", r.form, dec_form);
      cmp_bit("dec_mem", r.flg[2], dec_mem);
      cmp_bit("dec_word", r.flg[1], dec_word);
      cmp_bit("dec_illegal", r.flg[0], dec_illegal);
      cmp_clk("dec_min_clks", m, dec_min_clks);
      cmp_clk("dec_max_clks", m + (r.flg[2] ? 8'h02 : 8'h00),
              dec_max_clks);
      cmp_clk("dec_fetch_clks", 8'h00, dec_fetch_clks);
      accept();
   endtask

   task automatic do_reset(input logic nar);
      reset = 1'h1;
      narrow_strap = nar;
      repeat (5) @(posedge clk);
      #1;
      reset = 1'h0;
      cmp_bit("narrow_mode", nar, narrow_mode);
      cmp_bit("reset dec_valid", 1'h0, dec_valid);
      cmp_bit("reset fetch_ready", 1'h1, fetch_ready);
      cmp_form("reset dec_form", DMDT_F_NONE, dec_form);
      cmp_clk("reset dec_min_clks", 8'h00, dec_min_clks);
   endtask

   // Consumer stalls so the queue fills behind a pending result
   task automatic fill_and_flush(input logic nar);
      int t0;
      t0 = dmdt_fetch_model_inst.taken;
      repeat (9) dmdt_fetch_model_inst.push(8'h9F);
      repeat (25) @(posedge clk);
      #1;
      cmp_clk("bytes taken", nar ? 8'h05 : 8'h07,
              8'(dmdt_fetch_model_inst.taken - t0));
      cmp_bit("full fetch_ready", 1'h0, fetch_ready);
      cmp_form("pending form", DMDT_F_FLG_RD, dec_form);
      flush = 1'h1;
      @(posedge clk);
      #1;
      flush = 1'h0;
      stall = 1'h1;
      dmdt_fetch_model_inst.push(8'h9E);
      repeat (2) @(posedge clk);
      #1;
      cmp_bit("flushed dec_valid", 1'h0, dec_valid);
      cmp_bit("flushed fetch_ready", 1'h1, fetch_ready);
      repeat (2) @(posedge clk);
      #1;
      stall = 1'h0;
      wait_res();
      cmp_form("target form", DMDT_F_FLG_WR, dec_form);
      // Flush cycle plus five waiting cycles before the opcode is taken
      cmp_clk("target fetch", 8'h06, dec_fetch_clks);
      cmp_clk("target min", 8'h09, dec_min_clks);
      cmp_clk("target max", 8'h09, dec_max_clks);
      accept();
   endtask

   initial begin
      reset = 1'h1;
      narrow_strap = 1'h0;
      flush = 1'h0;
      stall = 1'h0;
      dec_ready = 1'h0;
      err_total = 0;
      checks = 0;
      for (int v = 0; v < 2; v++) begin
         do_reset(v[0]);
         foreach (rows[i])
            run_row(rows[i], v[0]);
         fill_and_flush(v[0]);
      end
      stop_test();
   end

   initial begin
      #200000;
      err_total++;
      $display("watchdog expired");
      stop_test();
   end
endmodule
`default_nettype wire
